// ==== pds_pkg.sv ====
/*
 * Constants for the drive power state machine: APB register map,
 * control bit positions, option codes and reset values.
 * Assumes a 32-bit APB bus with word-aligned registers.
 */
package pds_pkg;
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_OPTION    = 8'h04;
    localparam logic [7:0]  ADDR_STATE     = 8'h08;
    localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h0C;
    localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h10;
    // Control word bit positions
    localparam int          BIT_SWITCH_ON  = 0;
    localparam int          BIT_EN_VOLT    = 1;
    localparam int          BIT_QUICK_N    = 2;
    localparam int          BIT_EN_OP      = 3;
    localparam int          BIT_FAULT_RST  = 7;
    // Option register fields and codes; register reset values
    localparam int          QS_LSB         = 0;
    localparam int          ABORT_LSB      = 4;
    localparam logic [2:0]  QS_CODE_1      = 3'h1;
    localparam logic [2:0]  QS_CODE_3      = 3'h3;
    localparam logic [2:0]  QS_CODE_5      = 3'h5;
    localparam logic [2:0]  QS_CODE_7      = 3'h7;
    localparam logic [2:0]  ABORT_FAULT    = 3'h1;
    localparam logic [2:0]  ABORT_QSTOP    = 3'h3;
    localparam logic [15:0] CTRL_RESET     = 16'h0000;
    localparam logic [7:0]  OPTION_RESET   = 8'h02;
    // Interrupt status bits
    localparam int          IRQ_FAULT      = 0;
    localparam int          IRQ_QSTOP      = 1;
    localparam int          IRQ_DISABLED   = 2;
    localparam int          IRQ_W          = 3;

    typedef enum logic [3:0] {
        ST_START,
        ST_NOT_READY,
        ST_SWITCH_ON_DISABLED,
        ST_READY,
        ST_SWITCHED_ON,
        ST_OP_ENABLED,
        ST_QUICK_STOP,
        ST_FAULT_REACTION,
        ST_FAULT
    } power_drive_states_t;
endpackage

// ==== power_drive_fsm.sv ====
/*
 * Drive power state machine with APB register slave and interrupt.
 * Assumes status inputs are synchronous to pclk and that the
 * quick stop, retract and deceleration functions report completion
 * with level or pulse inputs.
 */
`timescale 1ns/1ps

module power_drive_fsm
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        init_done,
    input  wire logic        error_detected,
    input  wire logic        fault_cause,
    input  wire logic        main_power_on,
    input  wire logic        safe_torque_cutoff,
    input  wire logic        retract_trigger,
    input  wire logic        retract_done,
    input  wire logic        decel_done,
    input  wire logic        quick_stop_done,
    output logic             drive_enable,
    output logic             quick_stop_run,
    output logic             fault_reaction_run,
    output logic             irq
);
    pds_pkg::power_drive_states_t state;
    pds_pkg::power_drive_states_t next_state;
    logic [15:0]          ctrl;
    logic [15:0]          next_ctrl;
    logic [7:0]           option;
    logic [7:0]           next_option;
    logic [pds_pkg::IRQ_W-1:0] irq_stat;
    logic [pds_pkg::IRQ_W-1:0] next_irq_stat;
    logic [pds_pkg::IRQ_W-1:0] irq_mask;
    logic [pds_pkg::IRQ_W-1:0] next_irq_mask;
    logic [31:0]          next_prdata;
    logic                 next_pready;
    logic                 next_pslverr;
    logic                 next_irq;
    logic                 next_drive_enable;
    logic                 next_quick_stop_run;
    logic                 next_fault_reaction_run;
    logic                 cmd_shutdown;
    logic                 cmd_switch_on;
    logic                 cmd_enable_op;
    logic                 cmd_disable_volt;
    logic                 cmd_quick_stop;
    logic                 cmd_disable_op;
    logic                 cmd_fault_reset;
    logic                 fault_reset_q;
    logic [2:0]           qs_code;
    logic [2:0]           abort_code;
    logic                 power_fault;
    logic                 power_qstop;
    logic                 any_error;
    logic                 wr_acc;
    logic                 rd_acc;
    logic [pds_pkg::IRQ_W-1:0] irq_event;

    assign qs_code    = option[pds_pkg::QS_LSB +: 3];
    assign abort_code = option[pds_pkg::ABORT_LSB +: 3];
    assign wr_acc     = psel && penable && pwrite && !pready;
    assign rd_acc     = psel && penable && !pwrite && !pready;

    // Command decode; quick stop bit is active low
    always_comb
    begin
        cmd_fault_reset  = ctrl[pds_pkg::BIT_FAULT_RST] && !fault_reset_q;
        cmd_disable_volt = !ctrl[pds_pkg::BIT_FAULT_RST] && !ctrl[pds_pkg::BIT_EN_VOLT];
        cmd_quick_stop   = !ctrl[pds_pkg::BIT_FAULT_RST] && ctrl[pds_pkg::BIT_EN_VOLT]
                           && !ctrl[pds_pkg::BIT_QUICK_N];
        cmd_shutdown     = !ctrl[pds_pkg::BIT_FAULT_RST] && ctrl[pds_pkg::BIT_EN_VOLT]
                           && ctrl[pds_pkg::BIT_QUICK_N] && !ctrl[pds_pkg::BIT_SWITCH_ON];
        cmd_switch_on    = !ctrl[pds_pkg::BIT_FAULT_RST] && ctrl[pds_pkg::BIT_EN_VOLT]
                           && ctrl[pds_pkg::BIT_QUICK_N] && ctrl[pds_pkg::BIT_SWITCH_ON];
        cmd_enable_op    = cmd_switch_on && ctrl[pds_pkg::BIT_EN_OP];
        cmd_disable_op   = cmd_switch_on && !ctrl[pds_pkg::BIT_EN_OP];
    end

    // Power loss handling depends on abort option
    assign power_fault = !main_power_on && (abort_code == pds_pkg::ABORT_FAULT);
    assign power_qstop = !main_power_on && (abort_code == pds_pkg::ABORT_QSTOP);
    assign any_error   = error_detected || retract_trigger;

    always_comb
    begin
        next_state = state;
        unique case (state)
            pds_pkg::ST_START:
            begin
                if (init_done)
                    next_state = pds_pkg::ST_NOT_READY;
            end
            pds_pkg::ST_NOT_READY:
                next_state = pds_pkg::ST_SWITCH_ON_DISABLED;
            pds_pkg::ST_SWITCH_ON_DISABLED:
            begin
                if (cmd_shutdown && !safe_torque_cutoff)
                    next_state = pds_pkg::ST_READY;
            end
            pds_pkg::ST_READY:
            begin
                if (cmd_disable_volt || cmd_quick_stop || safe_torque_cutoff)
                    next_state = pds_pkg::ST_SWITCH_ON_DISABLED;
                else if (cmd_switch_on && main_power_on)
                    next_state = pds_pkg::ST_SWITCHED_ON;
            end
            pds_pkg::ST_SWITCHED_ON:
            begin
                if (cmd_disable_volt || cmd_quick_stop || safe_torque_cutoff)
                    next_state = pds_pkg::ST_SWITCH_ON_DISABLED;
                else if (cmd_shutdown)
                    next_state = pds_pkg::ST_READY;
                else if (cmd_enable_op && main_power_on)
                    next_state = pds_pkg::ST_OP_ENABLED;
            end
            pds_pkg::ST_OP_ENABLED:
            begin
                if (cmd_disable_volt || safe_torque_cutoff)
                    next_state = pds_pkg::ST_SWITCH_ON_DISABLED;
                else if (cmd_quick_stop || power_qstop)
                    next_state = pds_pkg::ST_QUICK_STOP;
                else if (cmd_shutdown)
                    next_state = pds_pkg::ST_READY;
                else if (cmd_disable_op || !main_power_on)
                    next_state = pds_pkg::ST_SWITCHED_ON;
            end
            pds_pkg::ST_QUICK_STOP:
            begin
                if (cmd_disable_volt || safe_torque_cutoff || !main_power_on)
                    next_state = pds_pkg::ST_SWITCH_ON_DISABLED;
                else if (quick_stop_done && qs_code >= pds_pkg::QS_CODE_1
                         && qs_code <= pds_pkg::QS_CODE_3)
                    next_state = pds_pkg::ST_SWITCH_ON_DISABLED;
                else if (cmd_enable_op && qs_code >= pds_pkg::QS_CODE_5
                         && qs_code <= pds_pkg::QS_CODE_7)
                    next_state = pds_pkg::ST_OP_ENABLED;
            end
            pds_pkg::ST_FAULT_REACTION:
            begin
                if (decel_done || retract_done)
                    next_state = pds_pkg::ST_FAULT;
            end
            pds_pkg::ST_FAULT:
            begin
                if (cmd_fault_reset && !fault_cause)
                    next_state = pds_pkg::ST_SWITCH_ON_DISABLED;
            end
            default:
                next_state = pds_pkg::ST_START;
        endcase
        // Error overrides everything outside start, fault reaction and fault; other commands fall through unchanged
        if ((any_error || power_fault) && state != pds_pkg::ST_START
            && state != pds_pkg::ST_FAULT_REACTION && state != pds_pkg::ST_FAULT)
            next_state = pds_pkg::ST_FAULT_REACTION;
    end

    // Drive outputs follow the next state so they line up with it
    always_comb
    begin
        next_drive_enable       = (next_state == pds_pkg::ST_OP_ENABLED)
                                  || (next_state == pds_pkg::ST_QUICK_STOP);
        next_quick_stop_run     = (next_state == pds_pkg::ST_QUICK_STOP);
        next_fault_reaction_run = (next_state == pds_pkg::ST_FAULT_REACTION);
    end

    // Register slave and sticky interrupts
    always_comb
    begin
        irq_event = '0;
        irq_event[pds_pkg::IRQ_FAULT]    = (next_state == pds_pkg::ST_FAULT_REACTION)
                                           && (state != pds_pkg::ST_FAULT_REACTION);
        irq_event[pds_pkg::IRQ_QSTOP]    = (next_state == pds_pkg::ST_QUICK_STOP)
                                           && (state != pds_pkg::ST_QUICK_STOP);
        irq_event[pds_pkg::IRQ_DISABLED] = (next_state == pds_pkg::ST_SWITCH_ON_DISABLED)
                                           && (state != pds_pkg::ST_SWITCH_ON_DISABLED);
        next_ctrl     = ctrl;
        next_option   = option;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        next_prdata   = prdata;
        next_pready   = 1'b0;
        next_pslverr  = 1'b0;
        if (wr_acc || rd_acc)
        begin
            next_pready = 1'b1;
            next_prdata = 32'h0000_0000;
            unique case (paddr)
                pds_pkg::ADDR_CTRL:
                begin
                    if (wr_acc)
                        next_ctrl = pwdata[15:0];
                    next_prdata = {16'h0000, ctrl};
                end
                pds_pkg::ADDR_OPTION:
                begin
                    if (wr_acc)
                        next_option = pwdata[7:0];
                    next_prdata = {24'h00_0000, option};
                end
                pds_pkg::ADDR_STATE:
                    next_prdata = {28'h000_0000, state};
                pds_pkg::ADDR_IRQ_STAT:
                begin
                    next_prdata = {29'h0000_0000, irq_stat};
                    if (rd_acc)
                        next_irq_stat = '0;
                end
                pds_pkg::ADDR_IRQ_MASK:
                begin
                    if (wr_acc)
                        next_irq_mask = pwdata[pds_pkg::IRQ_W-1:0];
                    next_prdata = {29'h0000_0000, irq_mask};
                end
                default:
                    next_pslverr = 1'b1;
            endcase
        end
        // Set wins over read-clear
        next_irq_stat = next_irq_stat | irq_event;
        next_irq      = |(next_irq_stat & next_irq_mask);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state              <= pds_pkg::ST_START;
            ctrl               <= pds_pkg::CTRL_RESET;
            option             <= pds_pkg::OPTION_RESET;
            irq_stat           <= '0;
            irq_mask           <= '0;
            prdata             <= 32'h0000_0000;
            pready             <= 1'b0;
            pslverr            <= 1'b0;
            irq                <= 1'b0;
            drive_enable       <= 1'b0;
            quick_stop_run     <= 1'b0;
            fault_reaction_run <= 1'b0;
            fault_reset_q      <= 1'b0;
        end
        else
        begin
            state              <= next_state;
            ctrl               <= next_ctrl;
            option             <= next_option;
            irq_stat           <= next_irq_stat;
            irq_mask           <= next_irq_mask;
            prdata             <= next_prdata;
            pready             <= next_pready;
            pslverr            <= next_pslverr;
            irq                <= next_irq;
            drive_enable       <= next_drive_enable;
            quick_stop_run     <= next_quick_stop_run;
            fault_reaction_run <= next_fault_reaction_run;
            // Fault reset acts on the rising edge of the bit only
            fault_reset_q      <= ctrl[pds_pkg::BIT_FAULT_RST];
        end
    end

    boot_auto_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == pds_pkg::ST_NOT_READY |=> state == pds_pkg::ST_SWITCH_ON_DISABLED)
        else $error("start-up did not reach switch-on-disabled");
    cutoff_block_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == pds_pkg::ST_SWITCH_ON_DISABLED && safe_torque_cutoff
        |=> state != pds_pkg::ST_READY)
        else $error("shutdown accepted under torque cutoff");
    power_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == pds_pkg::ST_READY && !main_power_on |=> state != pds_pkg::ST_SWITCHED_ON)
        else $error("switch on without main power");
    disable_op_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == pds_pkg::ST_OP_ENABLED && cmd_disable_op && !any_error && !safe_torque_cutoff
        |=> state == pds_pkg::ST_SWITCHED_ON)
        else $error("disable operation not honoured");
    volt_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == pds_pkg::ST_OP_ENABLED && cmd_disable_volt && !any_error && !power_fault
        |=> state == pds_pkg::ST_SWITCH_ON_DISABLED ##1 !drive_enable)
        else $error("disable voltage did not stop drive");
    qstop_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == pds_pkg::ST_OP_ENABLED && cmd_quick_stop && !cmd_disable_volt
        && !safe_torque_cutoff && !any_error && !power_fault
        |=> state == pds_pkg::ST_QUICK_STOP ##1 quick_stop_run)
        else $error("quick stop not entered");
    qstop_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == pds_pkg::ST_QUICK_STOP && quick_stop_done && qs_code == pds_pkg::QS_CODE_1
        && !any_error && !power_fault |=> state == pds_pkg::ST_SWITCH_ON_DISABLED)
        else $error("quick stop completion ignored");
    qstop_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == pds_pkg::ST_QUICK_STOP && qs_code < pds_pkg::QS_CODE_5
        |=> state != pds_pkg::ST_OP_ENABLED)
        else $error("quick stop left on enable with low code");
    fault_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == pds_pkg::ST_OP_ENABLED && error_detected
        |=> state == pds_pkg::ST_FAULT_REACTION ##1 fault_reaction_run)
        else $error("error did not start fault reaction");
    fault_done_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == pds_pkg::ST_FAULT_REACTION && decel_done
        |=> state == pds_pkg::ST_FAULT ##1 !drive_enable)
        else $error("fault reaction did not finish");
    fault_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == pds_pkg::ST_FAULT && fault_cause |=> state == pds_pkg::ST_FAULT)
        else $error("fault cleared with cause present");
endmodule

// ==== power_drive_master.sv ====
/*
 * Network master model: carries drive commands and register reads as APB transfers.
 * Assumes the bench calls xfer from a single process.
 */
`timescale 1ns/1ps
module power_drive_master
(
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end

    // No wait limit here; the bench timeout ends a hang
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        // Sampled at the rising edge, before the slave's flops update
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Released lines must not keep their last value
        paddr   <= ~addr;
        pwdata  <= ~wdata;
    endtask
endmodule

// ==== power_drive_fsm_tb_top.sv ====
/*
 * Self-checking bench for the drive power state machine.
 * Assumes the master model for APB and drives the status inputs itself.
 */
`timescale 1ns/1ps
module power_drive_fsm_tb_top;
    localparam logic [31:0] CMD_SHUTDOWN  = 32'h0000_0006;
    localparam logic [31:0] CMD_SWITCH_ON = 32'h0000_0007;
    localparam logic [31:0] CMD_ENABLE_OP = 32'h0000_000F;
    localparam logic [31:0] CMD_QSTOP     = 32'h0000_000B;
    localparam logic [31:0] CMD_FLT_RST   = 32'h0000_0080;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic        init_done, error_detected, fault_cause, main_power_on, safe_torque_cutoff;
    logic        retract_trigger, retract_done, decel_done, quick_stop_done, e;
    logic        drive_enable, quick_stop_run, fault_reaction_run;
    int          num_errors, cmp_count, cycles;

    power_drive_fsm dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .init_done(init_done), .error_detected(error_detected),
        .fault_cause(fault_cause), .main_power_on(main_power_on),
        .safe_torque_cutoff(safe_torque_cutoff), .retract_trigger(retract_trigger),
        .retract_done(retract_done), .decel_done(decel_done),
        .quick_stop_done(quick_stop_done), .drive_enable(drive_enable),
        .quick_stop_run(quick_stop_run), .fault_reaction_run(fault_reaction_run), .irq(irq));
    power_drive_master master_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Whole run is under a thousand cycles
    always @(posedge pclk)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        master_u.xfer(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a);
        master_u.xfer(1'b0, a, 32'h0000_0000, r, e);
    endtask

    task automatic expect_state(input pds_pkg::power_drive_states_t st);
        repeat (3) @(posedge pclk);
        rd(pds_pkg::ADDR_STATE);
        check("state", r, {28'h0000000, st});
    endtask

    task automatic go_enabled;
        wr(pds_pkg::ADDR_CTRL, CMD_SHUTDOWN);
        wr(pds_pkg::ADDR_CTRL, CMD_SWITCH_ON);
        wr(pds_pkg::ADDR_CTRL, CMD_ENABLE_OP);
        expect_state(pds_pkg::ST_OP_ENABLED);
    endtask

    task automatic fault_exit;
        wr(pds_pkg::ADDR_CTRL, 32'h0000_0000);
        wr(pds_pkg::ADDR_CTRL, CMD_FLT_RST);
        expect_state(pds_pkg::ST_SWITCH_ON_DISABLED);
    endtask

    task automatic test_startup;
        expect_state(pds_pkg::ST_START);
        @(posedge pclk) init_done <= 1'b1;
        expect_state(pds_pkg::ST_SWITCH_ON_DISABLED);
        rd(pds_pkg::ADDR_CTRL);
        check("ctrl reset", r, 32'h0000_0000);
        rd(pds_pkg::ADDR_OPTION);
        check("option reset", r, 32'h0000_0002);
        rd(pds_pkg::ADDR_IRQ_MASK);
        check("mask reset", r, 32'h0000_0000);
        rd(pds_pkg::ADDR_IRQ_STAT);
        check("status after start", r, 32'h0000_0004);
        rd(pds_pkg::ADDR_IRQ_STAT);
        check("status cleared", r, 32'h0000_0000);
        master_u.xfer(1'b1, 8'h14, 32'hFFFF_FFFF, r, e);
        check("unmapped error", {31'h0, e}, 32'h0000_0001);
        rd(8'h14);
        check("unmapped data", r, 32'h0000_0000);
    endtask

    task automatic test_shutdown_switch_on;
        @(posedge pclk) safe_torque_cutoff <= 1'b1;
        wr(pds_pkg::ADDR_CTRL, CMD_SHUTDOWN);
        expect_state(pds_pkg::ST_SWITCH_ON_DISABLED);
        @(posedge pclk) safe_torque_cutoff <= 1'b0;
        expect_state(pds_pkg::ST_READY);
        wr(pds_pkg::ADDR_CTRL, CMD_SWITCH_ON);
        expect_state(pds_pkg::ST_READY);
        @(posedge pclk) main_power_on <= 1'b1;
        expect_state(pds_pkg::ST_SWITCHED_ON);
        wr(pds_pkg::ADDR_CTRL, CMD_ENABLE_OP);
        expect_state(pds_pkg::ST_OP_ENABLED);
        check("drive_enable", {31'h0, drive_enable}, 32'h0000_0001);
        wr(pds_pkg::ADDR_CTRL, CMD_SWITCH_ON);
        expect_state(pds_pkg::ST_SWITCHED_ON);
        wr(pds_pkg::ADDR_CTRL, CMD_ENABLE_OP);
        expect_state(pds_pkg::ST_OP_ENABLED);
        @(posedge pclk) main_power_on <= 1'b0;
        expect_state(pds_pkg::ST_SWITCHED_ON);
        @(posedge pclk) main_power_on <= 1'b1;
        expect_state(pds_pkg::ST_OP_ENABLED);
        wr(pds_pkg::ADDR_CTRL, 32'h0000_0000);
        expect_state(pds_pkg::ST_SWITCH_ON_DISABLED);
        check("drive_enable off", {31'h0, drive_enable}, 32'h0000_0000);
        wr(pds_pkg::ADDR_CTRL, CMD_ENABLE_OP);
        expect_state(pds_pkg::ST_SWITCH_ON_DISABLED);
    endtask

    task automatic test_quick_stop;
        for (int c = 1; c <= 7; c++)
        begin
            if (c == 4)
                continue;
            wr(pds_pkg::ADDR_OPTION, 32'(c));
            go_enabled();
            wr(pds_pkg::ADDR_CTRL, CMD_QSTOP);
            expect_state(pds_pkg::ST_QUICK_STOP);
            check("quick_stop_run", {31'h0, quick_stop_run}, 32'h0000_0001);
            @(posedge pclk) quick_stop_done <= 1'b1;
            @(posedge pclk) quick_stop_done <= 1'b0;
            if (c < 4)
                expect_state(pds_pkg::ST_SWITCH_ON_DISABLED);
            else
            begin
                expect_state(pds_pkg::ST_QUICK_STOP);
                wr(pds_pkg::ADDR_CTRL, CMD_ENABLE_OP);
                expect_state(pds_pkg::ST_OP_ENABLED);
                check("drive_enable back", {31'h0, drive_enable}, 32'h0000_0001);
                wr(pds_pkg::ADDR_CTRL, 32'h0000_0000);
            end
        end
    endtask

    task automatic test_faults;
        wr(pds_pkg::ADDR_OPTION, 32'h0000_0002);
        rd(pds_pkg::ADDR_IRQ_STAT);
        wr(pds_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
        go_enabled();
        @(posedge pclk) error_detected <= 1'b1;
        @(posedge pclk) error_detected <= 1'b0;
        expect_state(pds_pkg::ST_FAULT_REACTION);
        check("fault_reaction_run", {31'h0, fault_reaction_run}, 32'h0000_0001);
        check("irq raised", {31'h0, irq}, 32'h0000_0001);
        @(posedge pclk) decel_done <= 1'b1;
        @(posedge pclk) decel_done <= 1'b0;
        expect_state(pds_pkg::ST_FAULT);
        check("drive_enable fault", {31'h0, drive_enable}, 32'h0000_0000);
        rd(pds_pkg::ADDR_IRQ_STAT);
        check("status fault", r, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        check("irq cleared", {31'h0, irq}, 32'h0000_0000);
        @(posedge pclk) fault_cause <= 1'b1;
        wr(pds_pkg::ADDR_CTRL, 32'h0000_0000);
        wr(pds_pkg::ADDR_CTRL, CMD_FLT_RST);
        expect_state(pds_pkg::ST_FAULT);
        // Cause cleared before the reset is sent again
        @(posedge pclk) fault_cause <= 1'b0;
        fault_exit();
        check("irq masked", {31'h0, irq}, 32'h0000_0000);
        wr(pds_pkg::ADDR_OPTION, 32'h0000_0012);
        go_enabled();
        @(posedge pclk) main_power_on <= 1'b0;
        @(posedge pclk) main_power_on <= 1'b1;
        expect_state(pds_pkg::ST_FAULT_REACTION);
        @(posedge pclk) decel_done <= 1'b1;
        @(posedge pclk) decel_done <= 1'b0;
        expect_state(pds_pkg::ST_FAULT);
        fault_exit();
        wr(pds_pkg::ADDR_OPTION, 32'h0000_0032);
        go_enabled();
        @(posedge pclk) main_power_on <= 1'b0;
        @(posedge pclk) main_power_on <= 1'b1;
        expect_state(pds_pkg::ST_QUICK_STOP);
        @(posedge pclk) quick_stop_done <= 1'b1;
        @(posedge pclk) quick_stop_done <= 1'b0;
        expect_state(pds_pkg::ST_SWITCH_ON_DISABLED);
        wr(pds_pkg::ADDR_OPTION, 32'h0000_0002);
        go_enabled();
        @(posedge pclk) retract_trigger <= 1'b1;
        @(posedge pclk) retract_trigger <= 1'b0;
        expect_state(pds_pkg::ST_FAULT_REACTION);
        @(posedge pclk) retract_done <= 1'b1;
        @(posedge pclk) retract_done <= 1'b0;
        expect_state(pds_pkg::ST_FAULT);
        fault_exit();
    endtask

    initial
    begin
        {init_done, error_detected, fault_cause, main_power_on, safe_torque_cutoff} = 5'h00;
        {retract_trigger, retract_done, decel_done, quick_stop_done} = 4'h0;
        presetn = 1'b0;
        num_errors = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        test_startup();
        test_shutdown_switch_on();
        test_quick_stop();
        test_faults();
        give_verdict();
    end
endmodule
